// ---- rtl/usb_sig_pkg.sv ----
// Package: constants and types for the bus signaling and interrupt block
// Summary of operation
// - Cancel withdraws pending unissued IN request
// - Status IN only on endpoint zero; interrupts
// - Host reset drives bus reset while requested
// - Device resume leaves suspend, remote wake
// - Host resume signals; release finishes resume
// - Host reports speed: low, full, high, unknown
// - Host suspend command suspends the bus
// - Per-source enable mask for control interrupts
// - Separate enable mask for endpoint interrupts
// - Enabled sources combine into one interrupt
// - Control status read returns and clears all
// - Host flags bus power error
// - Host flags attach and detach separately
// - Host flags device overrunning frame end
// - Host flags external supply fault
// - Device flags bus reset, sleep, session end
// - OTG flags session start, cable role done
// - Any mode flags frame start and wake
// - Endpoint status read returns and clears all
package usb_sig_pkg;

	// ************************************************************
	// Control flag positions
	// ************************************************************
	localparam int CTRL_W = 13;
	localparam int BUS_POWER_ERROR_BIT = 0;
	localparam int SESSION_START_BIT = 1;
	localparam int SESSION_END_BIT = 2;
	localparam int DETACH_BIT = 3;
	localparam int ATTACH_BIT = 4;
	localparam int FRAME_START_BIT = 5;
	localparam int OVERRUN_FRAME_BIT = 6;
	localparam int BUS_RESET_SEEN_BIT = 7;
	localparam int WAKE_SEEN_BIT = 8;
	localparam int SLEEP_SEEN_BIT = 9;
	localparam int CABLE_ROLE_DONE_BIT = 10;
	localparam int SUPPLY_FAULT_BIT = 11;
	localparam int STATUS_DONE_BIT = 12;
	localparam logic [CTRL_W-1:0] CONTROL_IRQ_FULL_MASK = 13'h1FFF;
	localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 13'h0000;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_DEVICE = 2'b00,
		MODE_HOST = 2'b01,
		MODE_OTG = 2'b10
	} op_mode_t;

	// Attached device speed codes
	typedef enum logic [1:0] {
		SPEED_LOW = 2'b00,
		SPEED_FULL = 2'b01,
		SPEED_HIGH = 2'b10,
		SPEED_UNKNOWN_CODE = 2'b11
	} speed_t;

	// Bus signaling state
	typedef enum logic [2:0] {
		SIG_IDLE = 3'b000,
		SIG_RESET = 3'b001,
		SIG_SUSPEND = 3'b010,
		SIG_RESUME = 3'b011,
		SIG_WAKE = 3'b100
	} sig_state_t;

	// Drive outputs toward the transceiver
	typedef struct packed {
		logic drive_reset;
		logic drive_resume;
		logic suspended;
	} line_drive_t;

	// Bus-side event strobes
	typedef struct packed {
		logic bus_power_error;
		logic session_start;
		logic session_end;
		logic detach;
		logic attach;
		logic frame_start;
		logic overrun_frame;
		logic bus_reset_seen;
		logic wake_seen;
		logic sleep_seen;
		logic cable_role_done;
		logic supply_fault;
		logic status_rcvd;
	} bus_events_t;

	// Timing figures in ms and derived cycles at 100 MHz
	localparam int CLK_KHZ = 100000;
	localparam int HOST_RESET_MIN_MS = 20;
	localparam int HOST_RESET_MIN_CYC = HOST_RESET_MIN_MS * CLK_KHZ;
	localparam int WAKE_MIN_MS = 10;
	localparam int WAKE_MAX_MS = 15;
	localparam int WAKE_MIN_CYC = WAKE_MIN_MS * CLK_KHZ;
	localparam int WAKE_MAX_CYC = WAKE_MAX_MS * CLK_KHZ;
	localparam int HOST_RESUME_MIN_MS = 20;
	localparam int HOST_RESUME_MIN_CYC = HOST_RESUME_MIN_MS * CLK_KHZ;

endpackage : usb_sig_pkg

// ---- rtl/usb_sig_ctrl.sv ----
// Module: host/device bus signaling control and interrupt reporting
`timescale 1ns/1ps
`default_nettype none
module usb_sig_ctrl
	import usb_sig_pkg::*;
#(
	parameter int EP_NUM = 16, // Endpoints including zero
	parameter int EP_W = 32, // Endpoint flag word width
	parameter int WAKE_MAX_CYCLES = WAKE_MAX_CYC // Remote-wake cutoff
) (
	input wire logic core_clk_in, // 100 MHz clock
	input wire logic rst_n_in, // Async reset, low
	input wire op_mode_t mode_in, // Operating mode
	input wire logic in_req_in, // Schedule IN pulse
	input wire logic in_cancel_in, // Cancel IN pulse
	input wire logic [3:0] in_ep_in, // Endpoint for IN req/cancel
	input wire logic in_issued_in, // Link issued pending IN
	input wire logic [3:0] in_issued_ep_in, // Endpoint issued
	input wire logic status_req_in, // Status IN on ep0 pulse
	input wire logic status_issued_in, // Link issued status IN
	input wire logic signal_drive_request_in, // Start/stop level
	input wire logic reset_cmd_in, // Reset request strobe
	input wire logic resume_cmd_in, // Resume request strobe
	input wire logic suspend_cmd_in, // Suspend command pulse
	input wire speed_t line_speed_in, // Detected line speed
	input wire logic attached_in, // Device attached level
	input wire bus_events_t events_in, // Bus event pulses
	input wire logic [EP_W-1:0] endpoint_irq_flags_in, // EP events
	input wire logic [CTRL_W-1:0] ctrl_en_set_in, // Enable set bits
	input wire logic [CTRL_W-1:0] ctrl_en_clr_in, // Enable clr bits
	input wire logic [EP_W-1:0] ep_en_set_in, // EP enable set
	input wire logic [EP_W-1:0] ep_en_clr_in, // EP enable clr
	input wire logic ctrl_status_rd_in, // Control status read
	input wire logic ep_status_rd_in, // Endpoint status read
	output logic [EP_NUM-1:0] in_pending_out, // Pending IN per ep
	output logic status_pending_out, // Status IN pending
	output line_drive_t line_drive_out, // Line signaling
	output speed_t speed_out, // Attached speed code
	output logic [CTRL_W-1:0] ctrl_en_out, // Control enable mask
	output logic [EP_W-1:0] ep_en_out, // Endpoint enable mask
	output logic [CTRL_W-1:0] ctrl_status_out, // Read data, control
	output logic [EP_W-1:0] ep_status_out, // Read data, endpoint
	output logic irq_out // Combined interrupt
);

	// ************************************************************
	// IN request scheduling
	// ************************************************************
	logic [EP_NUM-1:0] in_pend_r, in_pend_nxt; // Pending IN requests
	logic stat_pend_r, stat_pend_nxt; // Status IN pending
	logic is_host; // Host mode decode

	// Mode decode used in several places
	function automatic logic host_mode(input op_mode_t m);
		host_mode = (m == MODE_HOST);
	endfunction : host_mode

	assign is_host = host_mode(mode_in);

	// Cancel beats a same-cycle schedule so reconfiguration is safe
	always_comb begin
		in_pend_nxt = in_pend_r;
		if (in_issued_in) begin
			in_pend_nxt[in_issued_ep_in] = 1'b0; // Issued leaves queue
		end
		if (is_host && in_req_in) begin
			in_pend_nxt[in_ep_in] = 1'b1;
		end
		if (is_host && in_cancel_in) begin
			in_pend_nxt[in_ep_in] = 1'b0;
		end
		stat_pend_nxt = stat_pend_r;
		if (status_issued_in) begin
			stat_pend_nxt = 1'b0;
		end
		if (is_host && status_req_in) begin
			stat_pend_nxt = 1'b1; // Endpoint zero only
		end
	end

	// Register IN scheduling state
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			in_pend_r <= '0;
			stat_pend_r <= 1'b0;
		end else begin
			in_pend_r <= in_pend_nxt;
			stat_pend_r <= stat_pend_nxt;
		end
	end

	assign in_pending_out = in_pend_r;
	assign status_pending_out = stat_pend_r;

	// ************************************************************
	// Bus signaling state machine
	// ************************************************************
	sig_state_t sig_r, sig_nxt; // Signaling state
	logic [23:0] wake_cnt_r, wake_cnt_nxt; // Remote-wake duration

	// Software times the hold; the block only follows the request.
	// Remote wake is cut off at the maximum as a guard.
	always_comb begin
		sig_nxt = sig_r;
		wake_cnt_nxt = '0;
		unique case (sig_r)
			SIG_IDLE, SIG_SUSPEND: begin
				if (is_host && reset_cmd_in && signal_drive_request_in) begin
					sig_nxt = SIG_RESET;
				end else if (resume_cmd_in && signal_drive_request_in) begin
					sig_nxt = is_host ? SIG_RESUME : SIG_WAKE;
				end else if (is_host && suspend_cmd_in) begin
					sig_nxt = SIG_SUSPEND;
				end
			end
			SIG_RESET: begin
				if (reset_cmd_in && !signal_drive_request_in) begin
					sig_nxt = SIG_IDLE; // End reset
				end
			end
			SIG_RESUME: begin
				if (resume_cmd_in && !signal_drive_request_in) begin
					sig_nxt = SIG_IDLE; // Finish resume
				end
			end
			SIG_WAKE: begin
				wake_cnt_nxt = wake_cnt_r + 24'h000001;
				if ((resume_cmd_in && !signal_drive_request_in) ||
				    (32'(wake_cnt_r) >= WAKE_MAX_CYCLES)) begin
					sig_nxt = SIG_IDLE;
				end
			end
			default: begin
				sig_nxt = SIG_IDLE; // Illegal code recovers
			end
		endcase
	end

	// Register signaling state
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sig_r <= SIG_IDLE;
			wake_cnt_r <= '0;
		end else begin
			sig_r <= sig_nxt;
			wake_cnt_r <= wake_cnt_nxt;
		end
	end

	assign line_drive_out.drive_reset = (sig_r == SIG_RESET);
	assign line_drive_out.drive_resume = (sig_r == SIG_RESUME) ||
	                                     (sig_r == SIG_WAKE);
	assign line_drive_out.suspended = (sig_r == SIG_SUSPEND);

	// ************************************************************
	// Speed report
	// ************************************************************
	speed_t speed_r, speed_nxt; // Reported speed

	// Unknown when not host or nothing attached
	always_comb begin
		speed_nxt = (is_host && attached_in) ? line_speed_in :
		            SPEED_UNKNOWN_CODE;
	end

	// Register speed
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			speed_r <= SPEED_UNKNOWN_CODE;
		end else begin
			speed_r <= speed_nxt;
		end
	end

	assign speed_out = speed_r;

	// ************************************************************
	// Interrupt status and masks
	// ************************************************************
	logic [CTRL_W-1:0] cst_r, cst_nxt; // Control status
	logic [CTRL_W-1:0] cen_r, cen_nxt; // Control enables
	logic [EP_W-1:0] est_r, est_nxt; // Endpoint status
	logic [EP_W-1:0] een_r, een_nxt; // Endpoint enables
	logic [CTRL_W-1:0] cset; // Control set terms
	logic [CTRL_W-1:0] crd_r, crd_nxt; // Control read data
	logic [EP_W-1:0] erd_r, erd_nxt; // Endpoint read data
	logic irq_nxt; // Combined interrupt, next value

	// Event sources, mode-qualified except frame start and wake
	always_comb begin
		cset = '0;
		cset[BUS_POWER_ERROR_BIT] = is_host && events_in.bus_power_error;
		cset[ATTACH_BIT] = is_host && events_in.attach;
		cset[DETACH_BIT] = is_host && events_in.detach;
		cset[OVERRUN_FRAME_BIT] = is_host && events_in.overrun_frame;
		cset[SUPPLY_FAULT_BIT] = is_host && events_in.supply_fault;
		cset[BUS_RESET_SEEN_BIT] = (mode_in == MODE_DEVICE) &&
		                           events_in.bus_reset_seen;
		cset[SLEEP_SEEN_BIT] = (mode_in == MODE_DEVICE) &&
		                       events_in.sleep_seen;
		cset[SESSION_END_BIT] = (mode_in == MODE_DEVICE) &&
		                        events_in.session_end;
		cset[SESSION_START_BIT] = (mode_in == MODE_OTG) &&
		                          events_in.session_start;
		cset[CABLE_ROLE_DONE_BIT] = (mode_in == MODE_OTG) &&
		                            events_in.cable_role_done;
		cset[FRAME_START_BIT] = events_in.frame_start;
		cset[WAKE_SEEN_BIT] = events_in.wake_seen;
		cset[STATUS_DONE_BIT] = is_host && events_in.status_rcvd;
	end

	// Read returns and clears; a same-cycle event survives the clear
	always_comb begin
		cen_nxt = (cen_r | ctrl_en_set_in) & ~ctrl_en_clr_in;
		een_nxt = (een_r | ep_en_set_in) & ~ep_en_clr_in;
		crd_nxt = ctrl_status_rd_in ? cst_r : crd_r;
		erd_nxt = ep_status_rd_in ? est_r : erd_r;
		cst_nxt = (ctrl_status_rd_in ? CTRL_RESET_VAL : cst_r) | cset;
		est_nxt = (ep_status_rd_in ? '0 : est_r) |
		          endpoint_irq_flags_in;
		// Built from next values so the line rises with its flag
		irq_nxt = |(cst_nxt & cen_nxt & CONTROL_IRQ_FULL_MASK) ||
		          |(est_nxt & een_nxt);
	end

	// Register interrupt state
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cst_r <= CTRL_RESET_VAL;
			cen_r <= CTRL_RESET_VAL;
			est_r <= '0;
			een_r <= '0;
			crd_r <= CTRL_RESET_VAL;
			erd_r <= '0;
			irq_out <= 1'b0;
		end else begin
			cst_r <= cst_nxt;
			cen_r <= cen_nxt;
			est_r <= est_nxt;
			een_r <= een_nxt;
			crd_r <= crd_nxt;
			erd_r <= erd_nxt;
			irq_out <= irq_nxt;
		end
	end

	assign ctrl_en_out = cen_r;
	assign ep_en_out = een_r;
	assign ctrl_status_out = crd_r;
	assign ep_status_out = erd_r;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_cancel;
		is_host && in_cancel_in;
	endsequence

	property p_cancel;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		s_cancel |=> !in_pend_r[$past(in_ep_in)];
	endproperty
	a_cancel: assert property (p_cancel) else $error("cancel kept IN");

	property p_reset_start;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(sig_r == SIG_IDLE && is_host && reset_cmd_in &&
		 signal_drive_request_in) |=> line_drive_out.drive_reset;
	endproperty
	a_reset_start: assert property (p_reset_start)
		else $error("no reset");

	property p_resume_end;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(sig_r == SIG_RESUME && resume_cmd_in && !signal_drive_request_in)
		|=> !line_drive_out.drive_resume;
	endproperty
	a_resume_end: assert property (p_resume_end)
		else $error("resume stuck");

	property p_wake_cap;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		// While wake is still driven the count advances and stays capped
		(sig_r == SIG_WAKE) |=> !line_drive_out.drive_resume ||
		 ((wake_cnt_r == $past(wake_cnt_r) + 24'h000001) &&
		  (32'(wake_cnt_r) <= WAKE_MAX_CYCLES));
	endproperty
	a_wake_cap: assert property (p_wake_cap)
		else $error("wake too long");

	property p_speed;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		!(is_host && attached_in) |=> speed_out == SPEED_UNKNOWN_CODE;
	endproperty
	a_speed: assert property (p_speed) else $error("bad speed");

	property p_suspend;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(sig_r == SIG_IDLE && is_host && suspend_cmd_in && !reset_cmd_in &&
		 !resume_cmd_in) |=> line_drive_out.suspended;
	endproperty
	a_suspend: assert property (p_suspend) else $error("no suspend");

	property p_ctrl_clear;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		ctrl_status_rd_in |=> (ctrl_status_out == $past(cst_r)) &&
		                      (cst_r == $past(cset));
	endproperty
	a_ctrl_clear: assert property (p_ctrl_clear) else $error("ctrl rd");

	property p_ep_clear;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		ep_status_rd_in |=> est_r == $past(endpoint_irq_flags_in);
	endproperty
	a_ep_clear: assert property (p_ep_clear) else $error("ep rd");

	property p_irq;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		##1 irq_out == ((|(cst_r & cen_r)) || (|(est_r & een_r)));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	property p_frame;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		events_in.frame_start |=> cst_r[FRAME_START_BIT];
	endproperty
	a_frame: assert property (p_frame) else $error("frame lost");

endmodule : usb_sig_ctrl
`default_nettype wire

// ---- verif/usb_far_model.sv ----
// Far-side model: bus events, speed and link issue pulses
`timescale 1ns/1ps
`default_nettype none
module usb_far_model
	import usb_sig_pkg::*;
(
	input wire logic clk_in, // Core clock
	input wire logic rst_n_in, // Async reset, low
	input wire logic fire_in, // Raise one event
	input wire logic [3:0] which_in, // Control bit of the event
	input wire logic issue_in, // Issue the pending IN
	input wire logic stat_in, // Issue the status IN
	input wire speed_t speed_in, // Speed to present
	output bus_events_t events_out, // Event pulses
	output speed_t speed_out, // Line speed level
	output logic attached_out, // Attached level
	output logic issued_out, // IN issued pulse
	output logic stat_out // Status issued pulse
);
	// ****************************************
	// Pulse generator
	// ****************************************
	// Registered; each pulse is one clock late and as wide as the input that drives it
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			events_out <= '0;
			speed_out <= SPEED_UNKNOWN_CODE;
			attached_out <= 1'b0;
			issued_out <= 1'b0;
			stat_out <= 1'b0;
		end else begin
			// Control bit k sits at struct bit 12-k
			events_out <= fire_in ? bus_events_t'(13'h1000 >> which_in) : '0;
			speed_out <= speed_in;
			// Unknown speed doubles as nothing attached
			attached_out <= (speed_in != SPEED_UNKNOWN_CODE);
			issued_out <= issue_in;
			stat_out <= stat_in;
		end
	end
endmodule : usb_far_model
`default_nettype wire

// ---- verif/tb_usb_sig_ctrl.sv ----
// Testbench for the bus signaling and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_usb_sig_ctrl;
	import usb_sig_pkg::*;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clk, rst_n, req, cancel, sreq, sdr, rcmd, wcmd, scmd;
	logic crd, erd, fire, issue, stat;
	op_mode_t mode;
	speed_t spsel, lspd, spd;
	logic [3:0] ep, which;
	logic [31:0] epf, ees, eec, een, est;
	logic [12:0] ces, cec, cen, cst;
	bus_events_t ev;
	line_drive_t ld;
	logic att, iss, siss, spend, irq;
	logic [15:0] pend;
	int bad_count = 0; // Mismatches
	int samples_checked = 0; // Comparisons
	int n;
	// Mode in which each control flag is live
	op_mode_t mtab [13] = '{MODE_HOST, MODE_OTG, MODE_DEVICE, MODE_HOST,
		MODE_HOST, MODE_DEVICE, MODE_HOST, MODE_DEVICE, MODE_HOST,
		MODE_DEVICE, MODE_OTG, MODE_HOST, MODE_HOST};

	// Short wake cutoff keeps the run brief
	usb_sig_ctrl #(.WAKE_MAX_CYCLES(50)) u_usb_sig_ctrl (
		.core_clk_in(clk), .rst_n_in(rst_n), .mode_in(mode),
		.in_req_in(req), .in_cancel_in(cancel), .in_ep_in(ep),
		.in_issued_in(iss), .in_issued_ep_in(ep), .status_req_in(sreq),
		.status_issued_in(siss), .signal_drive_request_in(sdr),
		.reset_cmd_in(rcmd), .resume_cmd_in(wcmd), .suspend_cmd_in(scmd),
		.line_speed_in(lspd), .attached_in(att), .events_in(ev),
		.endpoint_irq_flags_in(epf), .ctrl_en_set_in(ces),
		.ctrl_en_clr_in(cec), .ep_en_set_in(ees), .ep_en_clr_in(eec),
		.ctrl_status_rd_in(crd), .ep_status_rd_in(erd),
		.in_pending_out(pend), .status_pending_out(spend),
		.line_drive_out(ld), .speed_out(spd), .ctrl_en_out(cen),
		.ep_en_out(een), .ctrl_status_out(cst), .ep_status_out(est),
		.irq_out(irq));

	usb_far_model u_usb_far_model (
		.clk_in(clk), .rst_n_in(rst_n), .fire_in(fire), .which_in(which),
		.issue_in(issue), .stat_in(stat), .speed_in(spsel),
		.events_out(ev), .speed_out(lspd), .attached_out(att),
		.issued_out(iss), .stat_out(siss));

	// ****************************************
	// Clock
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// One cycle; pulses drop at the falling edge after use
	task automatic step();
		@(negedge clk);
		{req, cancel, sreq, rcmd, wcmd, scmd, fire, issue, stat} = '0;
		{crd, erd, ces, cec, epf, ees, eec} = '0;
	endtask : step

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Event travels through the model, then lands in the flags
	task automatic fire_evt(input int k);
		which = 4'(k);
		fire = 1'b1;
		step();
		step();
	endtask : fire_evt

	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	// Guard against a hang anywhere
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_n = 1'b0;
		mode = MODE_HOST;
		ep = 4'h3;
		which = 4'h0;
		spsel = SPEED_UNKNOWN_CODE;
		sdr = 1'b0;
		step();
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		chk(spd, 32'h3);
		chk({pend, spend, ld, irq}, 32'h0);
		$display("test reset done");
		// Every flag in its own mode; all but frame start and wake refused in a wrong one
		ces = CONTROL_IRQ_FULL_MASK;
		step();
		chk(cen, CONTROL_IRQ_FULL_MASK);
		for (int k = 0; k < CTRL_W; k++) begin
			if (k != FRAME_START_BIT && k != WAKE_SEEN_BIT) begin
				mode = (mtab[k] == MODE_HOST) ? MODE_DEVICE : MODE_HOST;
				fire_evt(k);
				chk(irq, 32'h0);
			end
			mode = mtab[k];
			fire_evt(k);
			chk(irq, 32'h1);
			crd = 1'b1;
			step();
			chk(cst, 32'h1 << k);
			crd = 1'b1;
			step();
			chk({cst, irq}, 32'h0);
		end
		// Masked source raises no interrupt
		mode = MODE_HOST;
		cec = 13'h0020;
		step();
		chk(cen, 32'h1FDF);
		fire_evt(FRAME_START_BIT);
		chk(irq, 32'h0);
		crd = 1'b1;
		step();
		$display("test control done");
		// Endpoint mask and read-clear
		ees = 32'h1;
		step();
		chk(een, 32'h1);
		chk(cen, 32'h1FDF);
		epf = 32'h11;
		step();
		chk(irq, 32'h1);
		erd = 1'b1;
		step();
		chk(est, 32'h11);
		erd = 1'b1;
		step();
		chk(est, 32'h0);
		chk(irq, 32'h0);
		epf = 32'h10;
		step();
		chk(irq, 32'h0);
		erd = 1'b1;
		step();
		$display("test endpoint done");
		// IN cancel, same-cycle race, issue and refusal
		req = 1'b1;
		step();
		chk(pend, 32'h8);
		cancel = 1'b1;
		step();
		chk(pend, 32'h0);
		req = 1'b1;
		cancel = 1'b1;
		step();
		chk(pend, 32'h0);
		req = 1'b1;
		step();
		issue = 1'b1;
		step();
		step();
		chk(pend, 32'h0);
		mode = MODE_DEVICE;
		req = 1'b1;
		step();
		chk(pend, 32'h0);
		mode = MODE_HOST;
		// Status IN on endpoint zero
		sreq = 1'b1;
		step();
		chk(spend, 32'h1);
		stat = 1'b1;
		step();
		step();
		chk(spend, 32'h0);
		$display("test requests done");
		// Host reset, suspend, resume
		sdr = 1'b1;
		rcmd = 1'b1;
		step();
		step();
		chk(ld, 32'h4);
		sdr = 1'b0;
		rcmd = 1'b1;
		step();
		chk(ld, 32'h0);
		scmd = 1'b1;
		step();
		chk(ld, 32'h1);
		sdr = 1'b1;
		wcmd = 1'b1;
		step();
		chk(ld.drive_resume, 32'h1);
		sdr = 1'b0;
		wcmd = 1'b1;
		step();
		chk(ld, 32'h0);
		// Device remote wake, released by software then cut off
		mode = MODE_DEVICE;
		sdr = 1'b1;
		wcmd = 1'b1;
		step();
		chk(ld.drive_resume, 32'h1);
		sdr = 1'b0;
		wcmd = 1'b1;
		step();
		chk(ld.drive_resume, 32'h0);
		sdr = 1'b1;
		wcmd = 1'b1;
		step();
		n = 0;
		while (ld.drive_resume !== 1'b0 && n < 60) begin
			step();
			n++;
		end
		chk(n >= 45 && n <= 52, 32'h1);
		$display("test signaling done");
		// All four speed codes
		mode = MODE_HOST;
		for (int s = 0; s < 4; s++) begin
			spsel = speed_t'(s);
			step();
			step();
			chk(spd, 32'(s));
		end
		$display("test speed done");
		report_and_stop();
	end
endmodule : tb_usb_sig_ctrl
`default_nettype wire
